// ==== rtl/iox_executor.sv ====
// Processor end: executes the I/O instruction group
// Overview of operation
// R1: External branch clears latch bits 12-15, jumps
// R2: ROM fitted, idle: clear ROM flag, jump
// R3: Internal branch clears latch bits 12-15, jumps
// R4: Function: bits 10-15 device, 7-9 action
// R5: Function sends accumulator plus action bits
// R6: Rejected command branches and stores program
// R7: Word in loads accumulator from controller
// R8: Word out sends accumulator to controller
// R9: Controller drops its request on transfers
// R10: Bits 7-9 passed as order code
// R11: Status request loads controller status
// R12: Common interrogate loads line-15 service bits
// R13: Device 16 is bit 0, up to 31
// R14: Interrogate clears all service indicators
// R15: Interrogate is two words, no device code
// R16: Controller acknowledges within two microseconds
// R17: Missing acknowledge in window means rejected
`timescale 1ns/1ps
`default_nettype none
module iox_executor
   import iox_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic                cmd_valid,
   output logic                     cmd_ready,
   input  wire iox_op_t             cmd_op,
   input  wire logic [15:0]         cmd_instr,
   input  wire logic [ADDR_W-1:0]   cmd_ea,
   input  wire logic [WORD_W-1:0]   acc_in,
   input  wire logic                rom_fitted,
   input  wire logic                irq_in_service,
   input  wire logic                rom_mode_set,
   output logic                     done_pulse,
   output logic                     rejected_q,
   output logic                     pc_load_q,
   output logic [ADDR_W-1:0]        pc_q,
   output logic                     acc_load_q,
   output logic [WORD_W-1:0]        acc_q,
   output logic [WORD_W-1:0]        ext_latch_q,
   output logic [WORD_W-1:0]        int_latch_q,
   output logic                     rom_mode_q,
   iox_bus_if.cpu                   bus
);
   typedef enum logic [1:0] {
      IOX_IDLE = 2'b00,
      IOX_WAIT = 2'b01,
      IOX_DONE = 2'b11
   } iox_state_t;

   iox_state_t           state_q;
   iox_op_t              op_q;
   logic [15:0]          instr_q;
   logic [ADDR_W-1:0]    ea_q;
   logic [ACK_CW-1:0]    tmr_q;
   logic                 ack_rise;
   logic                 timeout;
   logic                 take;

   // Latch index from bits 12-15; bit 0 is the MSB, so low nibble
   function automatic logic [3:0] latch_sel(input logic [15:0] ins);
      return ins[LATCH_W-1:0];
   endfunction

   function automatic iox_stb_t strobe_of(input iox_op_t op);
      unique case (op)
         IOX_OP_FUNC:     return IOX_STB_FUNC;
         IOX_OP_WORD_IN:  return IOX_STB_IN;
         IOX_OP_WORD_OUT: return IOX_STB_OUT;
         IOX_OP_STATUS:   return IOX_STB_STATUS;
         IOX_OP_COMMON:   return IOX_STB_COMMON;
         default:         return IOX_STB_NONE;
      endcase
   endfunction

   assign take      = cmd_valid && (state_q == IOX_IDLE);
   assign cmd_ready = (state_q == IOX_IDLE);
   // Controller shares this clock; its ack is already a one-cycle pulse
   assign ack_rise  = bus.ack;
   assign timeout   = (tmr_q >= ACK_LIMIT);                  // [R17]
   assign done_pulse = (state_q == IOX_DONE);

   // Command capture and sequencing
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state_q <= IOX_IDLE;
         op_q    <= IOX_OP_BRANCH_EXT;
         instr_q <= WORD_RST;
         ea_q    <= ADDR_RST;
         tmr_q   <= '0;
      end
      else
      begin
         unique case (state_q)
            IOX_IDLE:
            begin
               tmr_q <= '0;
               if (cmd_valid)
               begin
                  op_q    <= cmd_op;
                  instr_q <= cmd_instr;
                  ea_q    <= cmd_ea;
                  // Branches finish at once, bus commands wait
                  if (strobe_of(cmd_op) == IOX_STB_NONE)
                     state_q <= IOX_DONE;
                  else
                     state_q <= IOX_WAIT;
               end
            end
            IOX_WAIT:
            begin
               tmr_q <= tmr_q + 1'b1;
               if (ack_rise || timeout)                      // [R16]
                  state_q <= IOX_DONE;
            end
            IOX_DONE:
               state_q <= IOX_IDLE;
            default:
               state_q <= IOX_IDLE;
         endcase
      end
   end

   // Bus drive: strobe held only while waiting for the acknowledge
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         bus.strobe   <= IOX_STB_NONE;
         bus.dev_addr <= '0;
         bus.order    <= '0;
         bus.data_out <= WORD_RST;
      end
      else if (take)
      begin
         bus.strobe   <= strobe_of(cmd_op);
         // Interrogate carries no device code: line 15 only [R15]
         bus.dev_addr <= (cmd_op == IOX_OP_COMMON) ? 6'(COMMON_LINE)
                         : cmd_instr[DEV_LSB +: DEV_W];          // [R4]
         bus.order    <= cmd_instr[ORD_LSB +: ORD_W];            // [R10]
         bus.data_out <= acc_in;                           // [R5] [R8]
      end
      else if (state_q == IOX_WAIT && (ack_rise || timeout))
         bus.strobe   <= IOX_STB_NONE;
   end

   // Completion: accumulator load, program counter, reject path
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         rejected_q <= 1'b0;
         pc_load_q  <= 1'b0;
         pc_q       <= ADDR_RST;
         acc_load_q <= 1'b0;
         acc_q      <= WORD_RST;
      end
      else
      begin
         rejected_q <= 1'b0;
         pc_load_q  <= 1'b0;
         acc_load_q <= 1'b0;
         if (state_q == IOX_IDLE && take
             && strobe_of(cmd_op) == IOX_STB_NONE)
         begin
            pc_load_q <= 1'b1;                         // [R1] [R3]
            pc_q      <= cmd_ea;
         end
         else if (state_q == IOX_WAIT && timeout && !ack_rise)
         begin
            // Simulated branch-and-store to the operand [R6] [R17]
            rejected_q <= 1'b1;
            pc_load_q  <= 1'b1;
            pc_q       <= ea_q;
         end
         else if (state_q == IOX_WAIT && ack_rise
                  && (op_q == IOX_OP_WORD_IN || op_q == IOX_OP_STATUS
                      || op_q == IOX_OP_COMMON))
         begin
            acc_load_q <= 1'b1;                   // [R7] [R11] [R12]
            acc_q      <= bus.data_in;
         end
      end
   end

   // Interrupt latches and read-only-memory mode flag
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ext_latch_q <= '0;
         int_latch_q <= '0;
         rom_mode_q  <= 1'b0;
      end
      else
      begin
         if (take && cmd_op == IOX_OP_BRANCH_INT)
            int_latch_q[latch_sel(cmd_instr)] <= 1'b0;         // [R3]
         if (take && cmd_op == IOX_OP_BRANCH_EXT)
         begin
            if (rom_fitted && !irq_in_service)
               rom_mode_q <= 1'b0;                             // [R2]
            else
               ext_latch_q[latch_sel(cmd_instr)] <= 1'b0;      // [R1]
         end
         // Mode entry beats a same-cycle clear by the branch
         if (rom_mode_set)
            rom_mode_q <= 1'b1;
         // External latch bit 15 is set by the bus request line; set wins
         if (bus.irq)
            ext_latch_q[COMMON_LINE] <= 1'b1;
      end
   end
endmodule : iox_executor
`default_nettype wire

// ==== rtl/iox_pkg.sv ====
// Shared constants and types for the I/O instruction executor link
package iox_pkg;
   // Instruction field positions (bit 0 is the most significant)
   localparam int DEV_LSB        = 0;   // device code bits 10-15
   localparam int DEV_W          = 6;
   localparam int ORD_LSB        = 6;   // order bits 7-9
   localparam int ORD_W          = 3;
   localparam int LATCH_W        = 4;   // latch select bits 12-15
   localparam int WORD_W         = 16;
   localparam int ACT_W          = 19;  // accumulator plus action bits
   localparam int ADDR_W         = 16;
   // Common interrupt line and its first device
   localparam int COMMON_LINE    = 15;
   localparam logic [5:0] COMMON_DEV0 = 6'h10;
   // Acknowledge window: 2 us at 50 MHz, longest time rounds down
   localparam int ACK_NS         = 2000;
   localparam int CLK_NS         = 20;
   localparam int ACK_CYC        = ACK_NS / CLK_NS;
   localparam int ACK_CW         = 8;
   localparam logic [7:0] ACK_LIMIT = 8'(ACK_CYC);
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] ADDR_RST = 16'h0000;

   typedef enum logic [2:0] {
      IOX_OP_BRANCH_EXT = 3'h0,
      IOX_OP_BRANCH_INT = 3'h1,
      IOX_OP_FUNC       = 3'h2,
      IOX_OP_WORD_IN    = 3'h3,
      IOX_OP_WORD_OUT   = 3'h4,
      IOX_OP_STATUS     = 3'h5,
      IOX_OP_COMMON     = 3'h6
   } iox_op_t;

   // Bus strobe kinds seen by controllers
   typedef enum logic [2:0] {
      IOX_STB_NONE   = 3'h0,
      IOX_STB_FUNC   = 3'h1,
      IOX_STB_IN     = 3'h2,
      IOX_STB_OUT    = 3'h3,
      IOX_STB_STATUS = 3'h4,
      IOX_STB_COMMON = 3'h5
   } iox_stb_t;
endpackage : iox_pkg

// ==== rtl/iox_bus_if.sv ====
// I/O bus between the processor executor and a device controller
`timescale 1ns/1ps
`default_nettype none
interface iox_bus_if;
   import iox_pkg::*;
   iox_stb_t             strobe;    // Command kind, held while waiting
   logic [DEV_W-1:0]     dev_addr;  // Device code
   logic [ORD_W-1:0]     order;     // Action or order bits
   logic [WORD_W-1:0]    data_out;  // Processor to controller
   logic [WORD_W-1:0]    data_in;   // Controller to processor
   logic                 ack;       // Acknowledge pulse
   logic                 irq;       // Controller interrupt request

   modport cpu (output strobe, output dev_addr, output order,
                output data_out, input data_in, input ack, input irq);
   modport ctrl (input strobe, input dev_addr, input order,
                 input data_out, output data_in, output ack, output irq);
endinterface : iox_bus_if
`default_nettype wire

// ==== rtl/iox_controller.sv ====
// Controller end: answers processor commands on the I/O bus
`timescale 1ns/1ps
`default_nettype none
module iox_controller
   import iox_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic [DEV_W-1:0]    my_addr,
   input  wire logic                on_common_line,
   input  wire logic                reject_all,
   input  wire logic [WORD_W-1:0]   dev_status,
   input  wire logic [WORD_W-1:0]   dev_rx_word,
   input  wire logic                svc_request,
   input  wire logic [WORD_W-1:0]   common_svc_in,
   output logic                     common_svc_clr,
   output logic                     func_pulse,
   output logic [ACT_W-1:0]         func_action_q,
   output logic                     tx_pulse,
   output logic [WORD_W-1:0]        tx_word_q,
   output logic [ORD_W-1:0]         order_q,
   iox_bus_if.ctrl                  bus
);
   logic       strobe_seen_q;
   logic       hit;
   logic       irq_q;
   iox_stb_t   stb_q;

   // Common interrogation addresses the line, not the device
   assign hit = (bus.strobe == IOX_STB_COMMON) ? on_common_line
              : (bus.strobe != IOX_STB_NONE && bus.dev_addr == my_addr);
   assign bus.irq = irq_q;
   assign stb_q   = bus.strobe;

   // At most one acknowledge per strobe (none while reject_all), one cycle later: well inside window
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         strobe_seen_q  <= 1'b0;
         bus.ack        <= 1'b0;
         bus.data_in    <= WORD_RST;
         func_pulse     <= 1'b0;
         func_action_q  <= '0;
         tx_pulse       <= 1'b0;
         tx_word_q      <= WORD_RST;
         order_q        <= '0;
         common_svc_clr <= 1'b0;
      end
      else
      begin
         func_pulse     <= 1'b0;
         tx_pulse       <= 1'b0;
         common_svc_clr <= 1'b0;
         bus.ack        <= 1'b0;
         if (!hit)
            strobe_seen_q <= 1'b0;
         else if (!strobe_seen_q && !reject_all)
         begin
            strobe_seen_q <= 1'b1;
            bus.ack       <= 1'b1;                            // [R16]
            order_q       <= bus.order;                       // [R10]
            unique case (stb_q)
               IOX_STB_FUNC:
               begin
                  func_pulse    <= 1'b1;                   // [R4] [R5]
                  func_action_q <= {bus.order, bus.data_out};
               end
               IOX_STB_IN:     bus.data_in <= dev_rx_word;        // [R7]
               IOX_STB_OUT:
               begin
                  tx_pulse  <= 1'b1;                              // [R8]
                  tx_word_q <= bus.data_out;
               end
               IOX_STB_STATUS: bus.data_in <= dev_status;        // [R11]
               IOX_STB_COMMON:
               begin
                  bus.data_in    <= common_svc_in;          // [R12] [R13]
                  common_svc_clr <= 1'b1;                        // [R14]
               end
               default:        bus.data_in <= bus.data_in;
            endcase
         end
      end
   end

   // Request line: transfer clears it, new request wins same cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         irq_q <= 1'b0;
      else if (svc_request)
         irq_q <= 1'b1;
      else if (hit && !strobe_seen_q && !reject_all
               && (stb_q == IOX_STB_IN || stb_q == IOX_STB_OUT))
         irq_q <= 1'b0;                                         // [R9]
   end
endmodule : iox_controller
`default_nettype wire

// ==== dv/iox_props.sv ====
// Bus checker for the executor to controller link
`timescale 1ns/1ps
`default_nettype none
module iox_props
   import iox_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              rst_b,
   input wire iox_stb_t          strobe,
   input wire logic [DEV_W-1:0]  dev_addr,
   input wire logic [ORD_W-1:0]  order,
   input wire logic [WORD_W-1:0] data_out,
   input wire logic              ack,
   input wire logic              irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // Bus phases; strobe start is the command launch
   sequence s_idle;
      strobe == IOX_STB_NONE;
   endsequence
   sequence s_launch;
      (strobe != IOX_STB_NONE) && ($past(strobe) == IOX_STB_NONE);
   endsequence
   wire logic xfer = ack && (strobe == IOX_STB_IN || strobe == IOX_STB_OUT);

   // Handshake and field stability while a command waits
   a_ack_one_cycle: assert property (ack |=> !ack)
      else $error("ack held longer than one cycle");
   a_ack_needs_cmd: assert property (ack |-> (strobe != IOX_STB_NONE) &&
      ($past(strobe) != IOX_STB_NONE)) else $error("ack without strobe");
   a_strobe_holds: assert property ((strobe != IOX_STB_NONE) |=>
      (strobe == $past(strobe)) || (strobe == IOX_STB_NONE))
      else $error("strobe kind changed mid command");
   a_fields_stable: assert property (((strobe != IOX_STB_NONE) &&
      ($past(strobe) != IOX_STB_NONE)) |-> $stable(dev_addr) && $stable(order))
      else $error("address or order moved under strobe");
   a_out_word_held: assert property (((strobe == IOX_STB_OUT) &&
      ($past(strobe) == IOX_STB_OUT)) |-> $stable(data_out))
      else $error("output word moved under strobe");
   a_wait_bounded: assert property (s_launch |-> ##[1:110] s_idle)
      else $error("strobe outlived the acknowledge window");
   a_ack_ends_cmd: assert property (ack |-> ##[1:6] s_idle)
      else $error("strobe not released after ack");
   a_common_line: assert property ((strobe == IOX_STB_COMMON) |->
      (dev_addr == 6'h0f)) else $error("interrogate not on line 15");
   a_irq_cleared: assert property (xfer |-> ##[0:2] !irq)
      else $error("request line kept after transfer");
endmodule // iox_props
`default_nettype wire

// ==== dv/io_instruction_executor_tb.sv ====
// Self-checking bench: executor and controller joined over the I/O bus
`timescale 1ns/1ps
`default_nettype none
module io_instruction_executor_tb
   import iox_pkg::*;
;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
   logic core_clk, rst_b, cmd_valid, rom_fitted, irq_in_service;
   logic rom_mode_set, reject_all, svc_request, cmd_ready, done_pulse;
   logic rejected_q, pc_load_q, acc_load_q, rom_mode_q, common_svc_clr;
   logic func_pulse, tx_pulse;
   iox_op_t           cmd_op;
   logic [15:0]       cmd_instr, cmd_ea, acc_in, pc_q, acc_q, ext_latch_q;
   logic [15:0]       int_latch_q, dev_status, dev_rx_word, common_svc_in;
   logic [15:0]       tx_word_q;
   logic [ACT_W-1:0]  func_action_q;
   logic [ORD_W-1:0]  order_q;
   logic [DEV_W-1:0]  my_addr = 6'h05;
   logic              on_common_line = 1'b1;
   logic [5:0]        seen;   // rej, pc, acc, tx, func, clr
   int                checked = 0, error_cnt = 0, cyc = 0;

   iox_bus_if iox_bus_if_i ();
   iox_executor iox_executor_i (.core_clk, .rst_b, .cmd_valid, .cmd_ready,
      .cmd_op, .cmd_instr, .cmd_ea, .acc_in, .rom_fitted, .irq_in_service,
      .rom_mode_set, .done_pulse, .rejected_q, .pc_load_q, .pc_q,
      .acc_load_q, .acc_q, .ext_latch_q, .int_latch_q, .rom_mode_q,
      .bus(iox_bus_if_i));
   iox_controller iox_controller_i (.core_clk, .rst_b, .my_addr,
      .on_common_line, .reject_all, .dev_status, .dev_rx_word, .svc_request,
      .common_svc_in, .common_svc_clr, .func_pulse, .func_action_q,
      .tx_pulse, .tx_word_q, .order_q, .bus(iox_bus_if_i));
   iox_props iox_props_i (.core_clk, .rst_b, .strobe(iox_bus_if_i.strobe),
      .dev_addr(iox_bus_if_i.dev_addr), .order(iox_bus_if_i.order),
      .data_out(iox_bus_if_i.data_out), .ack(iox_bus_if_i.ack),
      .irq(iox_bus_if_i.irq));

   // Free-running 50 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task end_sim;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard; rejects cost about 100 cycles each
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   function automatic logic [15:0] mk(logic [5:0] d, logic [2:0] o);
      return {7'h00, o, d};
   endfunction

   // One instruction: wait idle, present for one edge, gather pulses
   task automatic do_cmd(iox_op_t op, logic [15:0] ins, logic [15:0] ea);
      int n;
      seen = 6'h00;
      @(negedge core_clk);
      for (n = 0; n < 10 && cmd_ready !== 1'b1; n++)
         @(negedge core_clk);
      `CHK(cmd_ready, 1'b1)
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_instr = ins;
      cmd_ea = ea;
      for (n = 0; n < 200 && done_pulse !== 1'b1; n++)
      begin
         @(negedge core_clk);
         cmd_valid = 1'b0;
         seen |= {rejected_q, pc_load_q, acc_load_q, tx_pulse, func_pulse,
                  common_svc_clr};
      end
      `CHK(done_pulse, 1'b1)
   endtask

   task automatic pulse_in(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask

   task t_word_in;
      pulse_in(svc_request);
      `CHK(iox_bus_if_i.irq, 1'b1)
      dev_rx_word = 16'ha5c3;
      do_cmd(IOX_OP_WORD_IN, mk(6'h05, 3'h6), 16'h0040);
      `CHK(acc_q, 16'ha5c3)
      `CHK(seen[5:3], 3'b001)
      `CHK(iox_bus_if_i.irq, 1'b0)
      `CHK(order_q, 3'h6)
   endtask

   task t_branch_ext;
      do_cmd(IOX_OP_BRANCH_EXT, 16'h000f, 16'h1234);
      `CHK(pc_q, 16'h1234)
      `CHK(seen[4], 1'b1)
      `CHK(ext_latch_q, 16'h0000)
   endtask

   task t_rom;
      rom_fitted = 1'b1;
      pulse_in(rom_mode_set);
      `CHK(rom_mode_q, 1'b1)
      do_cmd(IOX_OP_BRANCH_EXT, 16'h000f, 16'h4321);
      `CHK(rom_mode_q, 1'b0)
      `CHK(pc_q, 16'h4321)
      irq_in_service = 1'b1;
      pulse_in(rom_mode_set);
      do_cmd(IOX_OP_BRANCH_EXT, 16'h000f, 16'h0777);
      `CHK(rom_mode_q, 1'b1)
      `CHK(pc_q, 16'h0777)
      rom_fitted = 1'b0;
   endtask

   task t_branch_int;
      do_cmd(IOX_OP_BRANCH_INT, 16'h0003, 16'hbeef);
      `CHK(pc_q, 16'hbeef)
      `CHK(int_latch_q, 16'h0000)
   endtask

   task t_out_func;
      acc_in = 16'h3c5a;
      do_cmd(IOX_OP_WORD_OUT, mk(6'h05, 3'h2), 16'h0050);
      `CHK(tx_word_q, 16'h3c5a)
      `CHK(seen[2], 1'b1)
      `CHK(order_q, 3'h2)
      acc_in = 16'h1234;
      do_cmd(IOX_OP_FUNC, mk(6'h05, 3'h5), 16'h0060);
      `CHK(func_action_q, {3'h5, 16'h1234})
      `CHK(seen[1], 1'b1)
   endtask

   task t_status_common;
      dev_status = 16'hbeef;
      do_cmd(IOX_OP_STATUS, mk(6'h05, 3'h0), 16'h0070);
      `CHK(acc_q, 16'hbeef)
      // Lopsided pattern so a reversed bit order shows up
      common_svc_in = 16'h8003;
      do_cmd(IOX_OP_COMMON, mk(6'h00, 3'h7), 16'h0080);
      `CHK(acc_q, 16'h8003)
      `CHK(seen[0], 1'b1)
      `CHK(order_q, 3'h7)
   endtask

   // Every bus command refused, then an absent device address
   task t_reject;
      int i;
      reject_all = 1'b1;
      for (i = 2; i < 7; i++)
      begin
         do_cmd(iox_op_t'(i), mk(6'h05, 3'h1), 16'h0100 + 16'(i));
         `CHK(seen[5], 1'b1)
         `CHK(pc_q, 16'h0100 + 16'(i))
      end
      reject_all = 1'b0;
      do_cmd(IOX_OP_WORD_IN, mk(6'h22, 3'h0), 16'h0200);
      `CHK(seen[5:4], 2'b11)
   endtask

   // Main sequence: reset for three cycles, then scenarios
   initial
   begin
      {rst_b, cmd_valid, rom_fitted, irq_in_service, rom_mode_set} = 5'h00;
      {reject_all, svc_request} = 2'b00;
      {cmd_instr, cmd_ea, acc_in, dev_status} = 64'h0;
      {dev_rx_word, common_svc_in} = 32'h0;
      cmd_op = IOX_OP_BRANCH_EXT;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst_b = 1'b1;
      t_word_in();
      t_branch_ext();
      t_rom();
      t_branch_int();
      t_out_func();
      t_status_common();
      t_reject();
      end_sim();
   end
endmodule // io_instruction_executor_tb
`default_nettype wire
